// *** rtl/cl_lat_regs.sv ***
// line-size and bus-hold registers with command choice and hold limiting
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module cl_lat_regs (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic soft_rst_in,
	input wire logic [cl_lat_pkg::ADDR_W-1:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	input wire logic bus_grant_in,
	input wire logic frame_strobe_pin,
	input wire cl_lat_pkg::xfer_req_t xfer_in,
	output cl_lat_pkg::mem_cmd_t cmd_out,
	output logic [7:0] prefetch_words_out,
	output logic end_burst_out
);
	import cl_lat_pkg::*;
	reg_req_t req;
	logic [7:0] line_q, line_d, hold_q, hold_d, rdata_q, rdata_d;
	logic [2:0] grant_s_q, grant_s_d, frame_s_q, frame_s_d;
	logic grant_lvl_q, grant_lvl_d, frame_lvl_q, frame_lvl_d;
	logic frame_prev_q, frame_prev_d;
	logic grant_ok, frame_ok, expired, counting;
	logic [7:0] age_q, age_d;
	assign req = '{wr: wr_in, rd: rd_in, addr: addr_in, wdata: wdata_in};
	// one decode of a register write, shared by the write logic and the checks
	function automatic logic wr_hit(input reg_req_t r, input logic [ADDR_W-1:0] ofs);
		return r.wr && r.addr == ofs;
	endfunction : wr_hit
	// three stages per pin; the first stage is read by the second only
	always_comb begin
		grant_s_d = {grant_s_q[1:0], bus_grant_in};
		frame_s_d = {frame_s_q[1:0], frame_strobe_pin};
		grant_lvl_d = grant_lvl_q;
		frame_lvl_d = frame_lvl_q;
		// accept a pin level only when stages two and three agree
		if (grant_s_q[1] == grant_s_q[2]) begin
			grant_lvl_d = grant_s_q[2];
		end
		if (frame_s_q[1] == frame_s_q[2]) begin
			frame_lvl_d = frame_s_q[2];
		end
		frame_prev_d = frame_lvl_q;
	end
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			grant_s_q <= 3'h0;
			frame_s_q <= 3'h0;
			grant_lvl_q <= 1'b0;
			frame_lvl_q <= 1'b0;
			frame_prev_q <= 1'b0;
		end else begin
			grant_s_q <= grant_s_d;
			frame_s_q <= frame_s_d;
			grant_lvl_q <= grant_lvl_d;
			frame_lvl_q <= frame_lvl_d;
			frame_prev_q <= frame_prev_d;
		end
	end
	assign grant_ok = grant_lvl_q;
	assign frame_ok = frame_lvl_q;
	// frame age kept apart from the timer, so the checks below do not trust it
	always_comb begin
		age_d = age_q;
		if (frame_ok && !frame_prev_q) begin
			age_d = 8'h01;
		end else if (!frame_ok) begin
			age_d = 8'h00;
		end else if (age_q != 8'h00 && age_q != 8'hff) begin
			age_d = age_q + 8'h01;
		end
	end
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			age_q <= 8'h00;
		end else begin
			age_q <= age_d;
		end
	end
	always_comb begin
		line_d = line_q;
		hold_d = hold_q;
		rdata_d = 8'h00;
		if (wr_hit(req, OFS_LINE)) begin
			// an unsupported length collapses to zero
			line_d = line_supported(req.wdata) ? req.wdata : LINE_OFF;
		end
		if (soft_rst_in) begin
			line_d = LINE_RESET;
		end
		if (wr_hit(req, OFS_HOLD)) begin
			hold_d = req.wdata;
		end
		// soft reset deliberately does not touch hold_d
		if (req.rd) begin
			unique case (req.addr)
				OFS_LINE: rdata_d = line_q;
				OFS_HOLD: rdata_d = hold_q;
				OFS_STAT: rdata_d = {6'h00, counting, expired};
				default: rdata_d = 8'h00;
			endcase
		end
	end
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			line_q <= LINE_RESET;
			hold_q <= HOLD_RESET;
			rdata_q <= 8'h00;
		end else begin
			line_q <= line_d;
			hold_q <= hold_d;
			rdata_q <= rdata_d;
		end
	end
	assign rdata_out = rdata_q;
	hold_timer u_timer (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.frame_start_in(frame_ok && !frame_prev_q),
		.frame_active_in(frame_ok),
		.grant_in(grant_ok),
		.limit_in(hold_q),
		.expired_out(expired),
		.counting_out(counting)
	);
	assign end_burst_out = expired;
	cmd_select u_cmd (
		.line_words_in(line_q),
		.xfer_in(xfer_in),
		.cmd_out(cmd_out),
		.prefetch_words_out(prefetch_words_out)
	);

	// register state and read port
	a_reset_vals: assert property (@(posedge clk_in)
		$fell(rst_in)
		|-> line_q == LINE_RESET && hold_q == HOLD_RESET && rdata_out == 8'h00)
		else $error("state not cleared by reset");

	a_line_zero: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_hit(req, OFS_LINE) && !line_supported(wdata_in) && !soft_rst_in
		|=> line_q == 8'h00)
		else $error("bad line length kept");

	a_line_keep: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_hit(req, OFS_LINE) && line_supported(wdata_in) && !soft_rst_in
		|=> line_q == $past(wdata_in))
		else $error("good line length lost");

	a_line_legal: assert property (@(posedge clk_in) disable iff (rst_in)
		1'b1
		|-> line_supported(line_q))
		else $error("illegal line length held");

	a_soft_line: assert property (@(posedge clk_in) disable iff (rst_in)
		soft_rst_in
		|=> line_q == LINE_RESET)
		else $error("soft reset kept line length");

	a_hold_write: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_hit(req, OFS_HOLD)
		|=> hold_q == $past(wdata_in))
		else $error("hold limit not written");

	a_hold_soft: assert property (@(posedge clk_in) disable iff (rst_in)
		soft_rst_in && !wr_hit(req, OFS_HOLD)
		|=> $stable(hold_q))
		else $error("soft reset changed hold limit");

	a_hold_other: assert property (@(posedge clk_in) disable iff (rst_in)
		!wr_hit(req, OFS_HOLD)
		|=> $stable(hold_q))
		else $error("hold limit changed without write");

	a_unmapped: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_in && addr_in > OFS_STAT && !soft_rst_in
		|=> $stable(line_q) && $stable(hold_q))
		else $error("unmapped write changed state");

	a_rd_idle: assert property (@(posedge clk_in) disable iff (rst_in)
		!rd_in
		|=> rdata_out == 8'h00)
		else $error("read data outside its cycle");

	a_line_read: assert property (@(posedge clk_in) disable iff (rst_in)
		rd_in && addr_in == OFS_LINE
		|=> rdata_out == $past(line_q))
		else $error("line length readback wrong");

	a_read_data: assert property (@(posedge clk_in) disable iff (rst_in)
		rd_in && addr_in == OFS_HOLD && !wr_in
		|=> rdata_out == $past(hold_q))
		else $error("hold limit readback wrong");

	a_stat_read: assert property (@(posedge clk_in) disable iff (rst_in)
		rd_in && addr_in == OFS_STAT
		|=> rdata_out == {6'h00, $past(counting), $past(expired)})
		else $error("status readback wrong");

	// command choice and prefetch length
	a_prefetch: assert property (@(posedge clk_in) disable iff (rst_in)
		line_q != 8'h00
		|-> prefetch_words_out == line_q)
		else $error("prefetch length wrong");

	a_prefetch_off: assert property (@(posedge clk_in) disable iff (rst_in)
		line_q == LINE_OFF
		|-> prefetch_words_out == 8'h01)
		else $error("disabled prefetch not single");

	a_wr_inv: assert property (@(posedge clk_in) disable iff (rst_in)
		cmd_out == CMD_MEM_WRITE_INV
		|-> line_q != 8'h00 && !xfer_in.is_read)
		else $error("invalidate without line");

	a_cmd_write: assert property (@(posedge clk_in) disable iff (rst_in)
		!xfer_in.is_read && (line_q == LINE_OFF || xfer_in.words < line_q)
		|-> cmd_out == CMD_MEM_WRITE)
		else $error("short write not plain");

	a_cmd_single: assert property (@(posedge clk_in) disable iff (rst_in)
		xfer_in.is_read && (line_q == LINE_OFF || xfer_in.words <= 8'h01)
		|-> cmd_out == CMD_MEM_READ)
		else $error("single read not plain");

	a_cmd_line: assert property (@(posedge clk_in) disable iff (rst_in)
		xfer_in.is_read && line_q != LINE_OFF && xfer_in.words > 8'h01 &&
		xfer_in.words <= line_q |-> cmd_out == CMD_MEM_READ_LINE)
		else $error("line read not chosen");

	a_cmd_mult: assert property (@(posedge clk_in) disable iff (rst_in)
		xfer_in.is_read && line_q != LINE_OFF && xfer_in.words > line_q
		|-> cmd_out == CMD_MEM_READ_MULT)
		else $error("multiple read not chosen");

	// pin synchronisers settle within a bounded lag
	a_grant_high: assert property (@(posedge clk_in) disable iff (rst_in)
		bus_grant_in [*5]
		|=> grant_ok)
		else $error("grant high not seen");

	a_grant_low: assert property (@(posedge clk_in) disable iff (rst_in)
		!bus_grant_in [*5]
		|=> !grant_ok)
		else $error("grant low not seen");

	a_frame_high: assert property (@(posedge clk_in) disable iff (rst_in)
		frame_strobe_pin [*5]
		|=> frame_ok)
		else $error("frame high not seen");

	a_frame_low: assert property (@(posedge clk_in) disable iff (rst_in)
		!frame_strobe_pin [*5]
		|=> !frame_ok)
		else $error("frame low not seen");

	// bus-hold timing
	a_age_match: assert property (@(posedge clk_in) disable iff (rst_in)
		1'b1
		|-> counting == (age_q != 8'h00))
		else $error("hold count not tied to frame");

	a_grant_free: assert property (@(posedge clk_in) disable iff (rst_in)
		grant_ok
		|-> !end_burst_out)
		else $error("limit hit with grant");

	a_expire: assert property (@(posedge clk_in) disable iff (rst_in)
		counting && !grant_ok && frame_ok && hold_q == 8'h00
		|-> end_burst_out)
		else $error("zero limit not enforced");

	a_expire_due: assert property (@(posedge clk_in) disable iff (rst_in)
		counting && !grant_ok && age_q >= hold_q
		|-> end_burst_out)
		else $error("reached limit not enforced");

	a_expire_cause: assert property (@(posedge clk_in) disable iff (rst_in)
		end_burst_out
		|-> counting && !grant_ok && age_q >= hold_q)
		else $error("burst ended before limit");

	c_expire: cover property (@(posedge clk_in) disable iff (rst_in) end_burst_out);

	c_bad_line: cover property (@(posedge clk_in) disable iff (rst_in)
		wr_in && addr_in == OFS_LINE && !line_supported(wdata_in));

	c_read_mult: cover property (@(posedge clk_in) disable iff (rst_in)
		cmd_out == CMD_MEM_READ_MULT);

	c_wr_inv: cover property (@(posedge clk_in) disable iff (rst_in)
		cmd_out == CMD_MEM_WRITE_INV);

	c_soft_keep: cover property (@(posedge clk_in) disable iff (rst_in)
		soft_rst_in && hold_q != 8'h00);
endmodule : cl_lat_regs

// *** rtl/cl_lat_pkg.sv ***
// package of constants and types for the line-size and bus-hold registers
// Operation
// - eight-bit host-written line length in words
// - line length picks master memory command
// - line length sizes slave prefetch bursts
// - unsupported line-size writes store zero
// - zero disabled, 4h 16B, 8h 32B
// - 10h 64B, 20h 128B, others unsupported
// - eight-bit bus-hold limit counted from frame
// - limit applies only after grant withdrawn
// - hardware reset clears bus-hold limit
// - software reset leaves bus-hold limit alone
package cl_lat_pkg;
	localparam int ADDR_W = 4;
	localparam logic [3:0] OFS_LINE = 4'h0;
	localparam logic [3:0] OFS_HOLD = 4'h1;
	localparam logic [3:0] OFS_STAT = 4'h2;
	localparam logic [7:0] LINE_RESET = 8'h00;
	localparam logic [7:0] HOLD_RESET = 8'h00;
	localparam logic [7:0] LINE_OFF = 8'h00;
	localparam logic [7:0] LINE_16B = 8'h04;
	localparam logic [7:0] LINE_32B = 8'h08;
	localparam logic [7:0] LINE_64B = 8'h10;
	localparam logic [7:0] LINE_128B = 8'h20;
	localparam int STAT_EXPIRE_BIT = 0;
	localparam int STAT_COUNTING_BIT = 1;

	typedef enum logic [2:0] {
		CMD_MEM_WRITE = 3'b000,
		CMD_MEM_WRITE_INV = 3'b001,
		CMD_MEM_READ = 3'b010,
		CMD_MEM_READ_LINE = 3'b011,
		CMD_MEM_READ_MULT = 3'b100
	} mem_cmd_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic is_read;
		logic [7:0] words;
	} xfer_req_t;

	function automatic logic line_supported(input logic [7:0] v);
		return v == LINE_OFF || v == LINE_16B || v == LINE_32B ||
			v == LINE_64B || v == LINE_128B;
	endfunction : line_supported
endpackage : cl_lat_pkg

// *** rtl/cmd_select.sv ***
// master memory command choice and slave prefetch length from the line length
`timescale 1ns/1ps
module cmd_select (
	input wire logic [7:0] line_words_in,
	input wire cl_lat_pkg::xfer_req_t xfer_in,
	output cl_lat_pkg::mem_cmd_t cmd_out,
	output logic [7:0] prefetch_words_out
);
	import cl_lat_pkg::*;
	logic line_on;
	assign line_on = line_words_in != LINE_OFF;
	always_comb begin
		// write-invalidate only when a write spans a whole line; a read of two or more words gets a line or multiple read only when the line length is enabled
		if (xfer_in.is_read) begin
			if (!line_on || xfer_in.words <= 8'h01) begin
				cmd_out = CMD_MEM_READ;
			end else if (xfer_in.words > line_words_in) begin
				cmd_out = CMD_MEM_READ_MULT;
			end else begin
				cmd_out = CMD_MEM_READ_LINE;
			end
		end else begin
			if (line_on && xfer_in.words >= line_words_in) begin
				cmd_out = CMD_MEM_WRITE_INV;
			end else begin
				cmd_out = CMD_MEM_WRITE;
			end
		end
		// disabled line length falls back to single-word prefetch
		prefetch_words_out = line_on ? line_words_in : 8'h01;
	end
endmodule : cmd_select

// *** rtl/hold_timer.sv ***
// bus-hold counter that runs from frame assertion
`timescale 1ns/1ps
module hold_timer (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic frame_start_in,
	input wire logic frame_active_in,
	input wire logic grant_in,
	input wire logic [7:0] limit_in,
	output logic expired_out,
	output logic counting_out
);
	logic [7:0] cnt_q, cnt_d;
	logic run_q, run_d;
	always_comb begin
		run_d = run_q;
		cnt_d = cnt_q;
		if (frame_start_in) begin
			run_d = 1'b1;
			cnt_d = 8'h01;
		end else if (!frame_active_in) begin
			run_d = 1'b0;
			cnt_d = 8'h00;
		end else if (run_q && cnt_q != 8'hff) begin
			cnt_d = cnt_q + 8'h01;
		end
	end
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_q <= 8'h00;
			run_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			run_q <= run_d;
		end
	end
	assign counting_out = run_q;
	// only an absent grant lets the limit bite
	assign expired_out = run_q && !grant_in && cnt_q >= limit_in;
endmodule : hold_timer

// *** bench/bus_party_model.sv ***
// far-side model that raises frame and drops grant part way through a burst
`timescale 1ns/1ps
module bus_party_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic go_in,
	input wire logic [7:0] frame_len_in,
	input wire logic [7:0] grant_len_in,
	output logic frame_out,
	output logic grant_out
);
	logic [7:0] cnt_q;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) cnt_q <= 8'h00;
		else if (go_in) cnt_q <= 8'h01;
		else if (cnt_q != 8'h00 && cnt_q < frame_len_in) cnt_q <= cnt_q + 8'h01;
		else cnt_q <= 8'h00;
	end
	assign frame_out = cnt_q != 8'h00;
	// grant parks high between bursts, as an idle arbiter would leave it
	assign grant_out = frame_out ? (cnt_q <= grant_len_in) : 1'b1;
endmodule : bus_party_model

// *** bench/tb_top.sv ***
// self-checking bench for the line-size and bus-hold registers
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
	$display("wrong value at %0t: mismatch", $time); end end
module tb_top;
	import cl_lat_pkg::*;
	logic clk_in = 0, rst_in = 1, soft_rst_in = 0, wr_in = 0, rd_in = 0, go = 0;
	logic [ADDR_W-1:0] addr_in = '0;
	logic [7:0] wdata_in = 8'h00, glen = 8'h00, rdata_out, pf, v, e, lim;
	logic grant, frame, end_burst, saw;
	logic [7:0] corner [8] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h20, 8'h03, 8'h21, 8'hff};
	xfer_req_t xfer_in = '0;
	mem_cmd_t cmd_out;
	int err_total = 0, check_count = 0;
	cl_lat_regs dut_u (.clk_in(clk_in), .rst_in(rst_in), .soft_rst_in(soft_rst_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .bus_grant_in(grant), .frame_strobe_pin(frame),
		.xfer_in(xfer_in), .cmd_out(cmd_out), .prefetch_words_out(pf),
		.end_burst_out(end_burst));
	bus_party_model far_u (.clk_in(clk_in), .rst_in(rst_in), .go_in(go),
		.frame_len_in(8'h1e), .grant_len_in(glen), .frame_out(frame), .grant_out(grant));
	initial forever #25 clk_in = ~clk_in;
	function automatic logic [7:0] exp_line(input logic [7:0] w);
		return (w == 8'h04 || w == 8'h08 || w == 8'h10 || w == 8'h20) ? w : 8'h00;
	endfunction : exp_line
	function automatic mem_cmd_t exp_cmd(input logic [7:0] l, input xfer_req_t x);
		if (!x.is_read) return (l != 8'h00 && x.words >= l) ? CMD_MEM_WRITE_INV : CMD_MEM_WRITE;
		if (l == 8'h00 || x.words <= 8'h01) return CMD_MEM_READ;
		return (x.words > l) ? CMD_MEM_READ_MULT : CMD_MEM_READ_LINE;
	endfunction : exp_cmd
	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge clk_in);
		wr_in <= 1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_in);
		wr_in <= 0;
	endtask : wr_reg
	task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [7:0] x);
		@(posedge clk_in);
		rd_in <= 1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 0;
		#1 `CHK(rdata_out, x)
	endtask : rd_reg
	// the pin synchronisers add a few cycles, so the window is generous
	task automatic burst(input logic [7:0] g, input logic want);
		@(posedge clk_in);
		go <= 1;
		glen <= g;
		@(posedge clk_in);
		go <= 0;
		saw = 0;
		repeat (45) begin
			@(posedge clk_in);
			#1 saw = saw | end_burst;
		end
		`CHK(saw, want)
	endtask : burst
	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : stop_test
	initial begin
		#200000;
		err_total++;
		stop_test();
	end
	initial begin
		void'($urandom(76223));
		repeat (4) @(posedge clk_in);
		rst_in <= 0;
		rd_reg(OFS_LINE, 8'h00);
		rd_reg(OFS_HOLD, 8'h00);
		for (int i = 0; i < 40; i++) begin
			v = (i < 8) ? corner[i] : 8'($urandom % 48);
			e = exp_line(v);
			wr_reg(OFS_LINE, v);
			rd_reg(OFS_LINE, e);
			@(posedge clk_in);
			xfer_in <= '{is_read: 1'($urandom), words: 8'($urandom % 48)};
			#1 `CHK(cmd_out, exp_cmd(e, xfer_in))
			`CHK(pf, (e == 8'h00) ? 8'h01 : e)
		end
		lim = 8'(3 + $urandom % 8);
		wr_reg(OFS_HOLD, lim);
		@(posedge clk_in);
		soft_rst_in <= 1;
		@(posedge clk_in);
		soft_rst_in <= 0;
		rd_reg(OFS_HOLD, lim);
		rd_reg(OFS_LINE, LINE_RESET);
		wr_reg(4'h9, 8'h5a);
		rd_reg(4'h9, 8'h00);
		burst(8'h02, 1'b1);
		burst(8'hff, 1'b0);
		// status while past the limit without grant, then idle after the frame
		@(posedge clk_in);
		go <= 1;
		glen <= 8'h02;
		@(posedge clk_in);
		go <= 0;
		repeat (20) @(posedge clk_in);
		rd_reg(OFS_STAT, 8'h03);
		repeat (20) @(posedge clk_in);
		rd_reg(OFS_STAT, 8'h00);
		stop_test();
	end
endmodule : tb_top
